// file: include/pm_cap_pkg.sv
/*
  Shared constants and carriers for the power-management capability register group.
  Assumes a configuration access port that presents dword addresses and byte enables.
*/
package pm_cap_pkg;

  // ------------------------------------------------------------------
  // configuration offsets (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [7:0]  CAP_PTR_OFS      = 8'h34;
  localparam logic [7:0]  HOST_CTRL_OFS    = 8'h40;
  localparam logic [7:0]  PM_HDR_OFS       = 8'h44;
  localparam logic [7:0]  PM_CAPS_OFS      = 8'h46;

  // ------------------------------------------------------------------
  // fixed values and reset values
  // ------------------------------------------------------------------
  localparam logic [7:0]  CAP_PTR_VAL      = 8'h44;
  localparam logic [7:0]  NEXT_ITEM_VAL    = 8'h00;
  localparam logic [7:0]  CAP_IDENT_VAL    = 8'h01;
  localparam logic [2:0]  PM_REVISION_VAL  = 3'h1;
  localparam logic        SWAP_RESET       = 1'b0;
  localparam logic [15:0] PM_HDR_RESET     = 16'h0001;
  localparam logic [15:0] PM_CAPS_RESET    = 16'h6401;

  // ------------------------------------------------------------------
  // capabilities word field positions
  // ------------------------------------------------------------------
  localparam int          WAKE_COLD_BIT    = 15;
  localparam int          WAKE_HOT_BIT     = 14;
  localparam int          WAKE_STATE2_BIT  = 13;
  localparam int          STATE2_FLAG_BIT  = 10;
  localparam int          SWAP_BIT         = 0;

  // ------------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [5:0]  dw_addr;
    logic [3:0]  byte_en;
    logic [31:0] wdata;
  } cfg_req_s;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
  } cfg_rsp_s;

  typedef struct packed {
    logic        wake_from_cold_off;
    logic        wake_mask_state2_ctrl;
    logic        low_power_state2_flag;
  } misc_mirror_s;

endpackage

// file: rtl/pm_capability_regs.sv
/*
  Configuration register group: host-control byte-swap bit, capabilities pointer,
  power-management capability header and capabilities word, plus the quadlet swapper.
  Assumes configuration requests, mirror bits and the eeprom load strobe all come
  from logic on clk_i; the miscellaneous configuration register lives elsewhere.
  Writes never stall or report an error; unmapped dwords simply read zero.
  The swapper is one register stage with no backpressure, so a quadlet may
  arrive every cycle; its output holds the last quadlet between strobes.
*/
// Behaviour
// - byte-swap enable set reverses byte order of every transferred quadlet, both ways
// - byte-swap enable is loaded from eeprom; zero for little-endian operation
// - host-control bits 31 to 1 always read zero
// - next-capability pointer byte reads zero, ending the list
// - capability identifier byte reads the power-management identifier 01h
// - wake-source field defaults to wake from state3-hot and state2
// - wake-source state2 bit follows bit 13 of miscellaneous configuration
// - state2 support bit mirrors bit 10 of miscellaneous configuration
// - state1 support bit always reads zero
// - dynamic power data bit always reads zero
// - capabilities pointer at 34h is read-only and returns 44h
// - low three capability bits report interface revision 001b
// - special-init, auxiliary-power and wake-clock bits read zero
module pm_capability_regs (
  input  wire logic                    clk_i,
  input  wire logic                    reset_i,
  input  wire pm_cap_pkg::cfg_req_s    cfg_req_i,
  output pm_cap_pkg::cfg_rsp_s         cfg_rsp_o,
  input  wire pm_cap_pkg::misc_mirror_s misc_i,
  input  wire logic                    eeprom_load_i,
  input  wire logic                    eeprom_swap_i,
  input  wire logic                    xfer_valid_i,
  input  wire logic [31:0]             xfer_data_i,
  output logic                         xfer_valid_o,
  output logic [31:0]                  xfer_data_o,
  output logic                         swap_en_o
);
  import pm_cap_pkg::*;

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  // reverse the four bytes of a quadlet
  function automatic logic [31:0] byte_swap(input logic [31:0] q);
    byte_swap = {q[7:0], q[15:8], q[23:16], q[31:24]};
  endfunction

  // dword index of a byte offset
  function automatic logic [5:0] dw_of(input logic [7:0] ofs);
    dw_of = ofs[7:2];
  endfunction

  // live capabilities word; mirror bits follow the misc register directly
  function automatic logic [15:0] caps_word(input misc_mirror_s m);
    logic [15:0] w;
    w                  = 16'h0000;
    w[WAKE_COLD_BIT]   = m.wake_from_cold_off;
    w[WAKE_HOT_BIT]    = 1'b1;
    w[WAKE_STATE2_BIT] = m.wake_mask_state2_ctrl;
    w[STATE2_FLAG_BIT] = m.low_power_state2_flag;
    w[2:0]             = PM_REVISION_VAL;
    caps_word = w;
  endfunction

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  logic        swap_r;
  logic        swap_nxt;
  cfg_rsp_s    rsp_r;
  cfg_rsp_s    rsp_nxt;
  logic        xv_r;
  logic        xv_nxt;
  logic [31:0] xd_r;
  logic [31:0] xd_nxt;
  logic        host_wr;

  // ------------------------------------------------------------------
  // byte-swap control bit
  // ------------------------------------------------------------------
  // only byte lane 0 of the host-control dword can change anything
  assign host_wr = cfg_req_i.valid && cfg_req_i.write && cfg_req_i.byte_en[0]
                   && (cfg_req_i.dw_addr == dw_of(HOST_CTRL_OFS));

  // eeprom load wins over a config write in the same cycle
  always_comb begin
    swap_nxt = swap_r;
    if (eeprom_load_i) begin
      swap_nxt = eeprom_swap_i;
    end else if (host_wr) begin
      swap_nxt = cfg_req_i.wdata[SWAP_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      swap_r <= SWAP_RESET;
    end else begin
      swap_r <= swap_nxt;
    end
  end

  // ------------------------------------------------------------------
  // configuration read path
  // ------------------------------------------------------------------
  // every request acks next cycle; unmapped dwords read zero, writes drop
  always_comb begin
    rsp_nxt       = '0;
    rsp_nxt.ack   = cfg_req_i.valid;
    if (cfg_req_i.valid && !cfg_req_i.write) begin
      unique case (cfg_req_i.dw_addr)
        dw_of(CAP_PTR_OFS): begin
          rsp_nxt.rdata[7:0] = CAP_PTR_VAL;
        end
        dw_of(HOST_CTRL_OFS): begin
          rsp_nxt.rdata[SWAP_BIT] = swap_r;
        end
        dw_of(PM_HDR_OFS): begin
          rsp_nxt.rdata = {caps_word(misc_i), NEXT_ITEM_VAL, CAP_IDENT_VAL};
        end
        default: begin
          rsp_nxt.rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rsp_r <= '0;
    end else begin
      rsp_r <= rsp_nxt;
    end
  end

  // ------------------------------------------------------------------
  // quadlet swapper on the bus data path
  // ------------------------------------------------------------------
  // one register stage; the same swap serves reads and writes
  always_comb begin
    xv_nxt = xfer_valid_i;
    xd_nxt = xd_r;
    if (xfer_valid_i) begin
      xd_nxt = swap_r ? byte_swap(xfer_data_i) : xfer_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      xv_r <= 1'b0;
      xd_r <= 32'h0000_0000;
    end else begin
      xv_r <= xv_nxt;
      xd_r <= xd_nxt;
    end
  end

  // every output comes straight from a register
  assign cfg_rsp_o    = rsp_r;
  assign swap_en_o    = swap_r;
  assign xfer_valid_o = xv_r;
  assign xfer_data_o  = xd_r;

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  // decoded read requests used by the checks below
  logic rd_host;
  logic rd_hdr;
  logic rd_ptr;
  assign rd_host = cfg_req_i.valid && !cfg_req_i.write
                   && cfg_req_i.dw_addr == dw_of(HOST_CTRL_OFS);
  assign rd_hdr  = cfg_req_i.valid && !cfg_req_i.write
                   && cfg_req_i.dw_addr == dw_of(PM_HDR_OFS);
  assign rd_ptr  = cfg_req_i.valid && !cfg_req_i.write
                   && cfg_req_i.dw_addr == dw_of(CAP_PTR_OFS);

  // swapper output uses the swap bit held at the take edge
  a_swap_datapath: assert property (
    xfer_valid_i |=> xfer_valid_o && xfer_data_o ==
      ($past(swap_r) ? byte_swap($past(xfer_data_i)) : $past(xfer_data_i)))
    else $error("quadlet swap wrong");

  // a load takes effect on the next edge, whatever else happens
  a_eeprom_load: assert property (
    eeprom_load_i |=> swap_en_o == $past(eeprom_swap_i))
    else $error("eeprom load not taken");

  // host-control reads show only the swap bit
  a_host_read: assert property (
    rd_host |=> cfg_rsp_o.ack && cfg_rsp_o.rdata == {31'h0, $past(swap_r)})
    else $error("host control read wrong");

  // header half of the shared dword is fixed
  a_cap_header: assert property (
    rd_hdr |=> cfg_rsp_o.rdata[15:0] == PM_HDR_RESET)
    else $error("capability header wrong");

  // wake and state2 bits follow the live mirror inputs
  a_wake_mirror: assert property (
    rd_hdr |=> cfg_rsp_o.rdata[30] && cfg_rsp_o.rdata[28:27] == 2'b00
      && cfg_rsp_o.rdata[29] == $past(misc_i.wake_mask_state2_ctrl)
      && cfg_rsp_o.rdata[26] == $past(misc_i.low_power_state2_flag)
      && cfg_rsp_o.rdata[31] == $past(misc_i.wake_from_cold_off))
    else $error("wake or state2 mirror wrong");

  // every fixed capability bit below the state2 flag
  a_fixed_caps: assert property (
    rd_hdr |=> cfg_rsp_o.rdata[25:16] == 10'h001)
    else $error("fixed capability bits wrong");

  // pointer dword returns the header offset and nothing else
  a_cap_pointer: assert property (
    rd_ptr |=> cfg_rsp_o.rdata == 32'h0000_0044)
    else $error("capabilities pointer wrong");

  // writes off bit 0 of host control change nothing and answer zero
  a_ro_write_ignored: assert property (
    (cfg_req_i.valid && cfg_req_i.write && !host_wr && !eeprom_load_i)
      |=> $stable(swap_r) && cfg_rsp_o.ack && cfg_rsp_o.rdata == 32'h0000_0000)
    else $error("read-only write had effect");

  // ------------------------------------------------------------------
  // reset, idle and hold checks
  // ------------------------------------------------------------------
  // reset must clear every output even though the default disable masks it
  a_reset_clear: assert property (disable iff (1'b0)
    reset_i |=> !cfg_rsp_o.ack && cfg_rsp_o.rdata == 32'h0000_0000 && !swap_en_o
      && !xfer_valid_o && xfer_data_o == 32'h0000_0000)
    else $error("outputs not cleared by reset");

  // no request, no answer and no stray data
  a_idle_no_ack: assert property (
    !cfg_req_i.valid |=> !cfg_rsp_o.ack && cfg_rsp_o.rdata == 32'h0000_0000)
    else $error("answer without request");

  // every request is answered, writes included, so no access can hang
  a_ack_each_request: assert property (
    cfg_req_i.valid |=> cfg_rsp_o.ack)
    else $error("request not answered");

  // a lane-0 host write stores bit 0 unless a load overrides it
  a_host_write: assert property (
    host_wr && !eeprom_load_i |=> swap_en_o == $past(cfg_req_i.wdata[SWAP_BIT]))
    else $error("host write to swap bit lost");

  // with neither a load nor a lane-0 write the swap bit never moves
  a_swap_hold: assert property (
    !eeprom_load_i && !host_wr |=> $stable(swap_en_o))
    else $error("swap bit changed on its own");

  // an idle cycle drops the valid strobe and keeps the last quadlet
  a_data_hold: assert property (
    !xfer_valid_i |=> !xfer_valid_o && $stable(xfer_data_o))
    else $error("swapper output moved while idle");

  // ------------------------------------------------------------------
  // fixed capability fields, one rule each
  // ------------------------------------------------------------------
  // reset mirror setting must give the reset capabilities word
  a_caps_default: assert property (
    rd_hdr && misc_i == 3'b011 |=> cfg_rsp_o.rdata[31:16] == PM_CAPS_RESET)
    else $error("default capabilities word wrong");

  // next pointer of zero closes the capability list
  a_next_item_zero: assert property (
    rd_hdr |=> cfg_rsp_o.rdata[15:8] == 8'h00)
    else $error("next item pointer not zero");

  // power-management identifier in the low byte
  a_cap_identifier: assert property (
    rd_hdr |=> cfg_rsp_o.rdata[7:0] == 8'h01)
    else $error("capability identifier wrong");

  // state1 is not implemented, so it is never advertised
  a_state1_zero: assert property (
    rd_hdr |=> !cfg_rsp_o.rdata[25])
    else $error("state1 support advertised");

  // no dynamic power data is reported
  a_power_report_zero: assert property (
    rd_hdr |=> !cfg_rsp_o.rdata[24])
    else $error("power report bit set");

  // interface revision code in the low three bits
  a_revision_code: assert property (
    rd_hdr |=> cfg_rsp_o.rdata[18:16] == 3'b001)
    else $error("revision code wrong");

  // special-init, auxiliary-power and wake-clock bits stay clear
  a_special_bits_zero: assert property (
    rd_hdr |=> cfg_rsp_o.rdata[21:19] == 3'b000)
    else $error("special capability bit set");

  // reads of dwords this group does not own
  logic rd_other;
  assign rd_other = cfg_req_i.valid && !cfg_req_i.write
                    && !rd_host && !rd_hdr && !rd_ptr;

  // unmapped reads answer with zero rather than an error
  a_unmapped_zero: assert property (
    rd_other |=> cfg_rsp_o.ack && cfg_rsp_o.rdata == 32'h0000_0000)
    else $error("unmapped read not zero");

  // main scenarios the bench is expected to reach
  c_swapped_xfer: cover property (swap_r && xfer_valid_i ##1 xfer_valid_o);
  c_host_set:     cover property (host_wr && cfg_req_i.wdata[0] ##1 swap_en_o);
  c_hdr_read:     cover property (rd_hdr ##1 cfg_rsp_o.ack);
  c_load_beats_write: cover property (eeprom_load_i && host_wr ##1 !swap_en_o);
  c_unmapped_read:    cover property (rd_other ##1 cfg_rsp_o.ack);

endmodule

// file: bench/cfg_host_model.sv
/*
  host model issuing configuration accesses to the register group.
  assumes the answer is registered on the take edge itself and read just after it.
*/
module cfg_host_model (
  input  wire logic                 clk_i,
  output pm_cap_pkg::cfg_req_s      req_o,
  input  wire pm_cap_pkg::cfg_rsp_s rsp_i
);
  timeunit 1ns;
  timeprecision 1ns;
  import pm_cap_pkg::*;

  initial req_o = '0;

  // one request per call; fields scrambled afterwards so stale values are never trusted
  task automatic access(input logic wr, input logic [5:0] dw, input logic [3:0] be,
                        input logic [31:0] wd, output logic [31:0] rd, output logic ok);
    @(posedge clk_i) #1;
    req_o = '{valid: 1'b1, write: wr, dw_addr: dw, byte_en: be, wdata: wd};
    @(posedge clk_i) #1;
    req_o.valid = 1'b0;
    req_o.wdata = ~wd;
    req_o.dw_addr = ~dw;
    ok = rsp_i.ack;
    rd = rsp_i.rdata;
  endtask
endmodule

// file: bench/tb.sv
/*
  self-checking bench: config reads and writes, quadlet swapper, eeprom load.
  assumes the host model in cfg_host_model and a 10 MHz clock.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import pm_cap_pkg::*;

  logic         clk_i = 1'b0;
  logic         reset_i = 1'b1;
  logic         eeprom_load_i = 1'b0;
  logic         eeprom_swap_i = 1'b0;
  logic         xfer_valid_i = 1'b0;
  logic [31:0]  xfer_data_i = 32'h0000_0000;
  logic [31:0]  rd;
  logic [31:0]  xfer_data_o;
  logic         ok;
  logic         xfer_valid_o;
  logic         swap_en_o;
  cfg_req_s     req;
  cfg_rsp_s     rsp;
  misc_mirror_s misc_i = 3'b011;
  int           fails = 0;
  int           samples_checked = 0;

  always #50 clk_i = ~clk_i;

  cfg_host_model u_cfg_host_model (.clk_i(clk_i), .req_o(req), .rsp_i(rsp));

  pm_capability_regs u_pm_capability_regs (.clk_i(clk_i), .reset_i(reset_i),
    .cfg_req_i(req), .cfg_rsp_o(rsp), .misc_i(misc_i), .eeprom_load_i(eeprom_load_i),
    .eeprom_swap_i(eeprom_swap_i), .xfer_valid_i(xfer_valid_i), .xfer_data_i(xfer_data_i),
    .xfer_valid_o(xfer_valid_o), .xfer_data_o(xfer_data_o), .swap_en_o(swap_en_o));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [5:0] dw, input logic [31:0] exp);
    u_cfg_host_model.access(1'b0, dw, 4'hf, 32'h0000_0000, rd, ok);
    check({31'h0, ok}, 32'h0000_0001);
    check(rd, exp);
  endtask

  task automatic wr(input logic [5:0] dw, input logic [3:0] be, input logic [31:0] wd);
    u_cfg_host_model.access(1'b1, dw, be, wd, rd, ok);
    check({31'h0, ok}, 32'h0000_0001);
  endtask

  // data is inverted once dropped so a held value cannot pass by luck
  task automatic xfer(input logic [31:0] d, input logic [31:0] exp);
    @(posedge clk_i) #1;
    xfer_valid_i = 1'b1;
    xfer_data_i = d;
    @(posedge clk_i) #1;
    xfer_valid_i = 1'b0;
    xfer_data_i = ~d;
    check({31'h0, xfer_valid_o}, 32'h0000_0001);
    check(xfer_data_o, exp);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // hang guard; the run needs far fewer cycles
  initial begin
    repeat (5000) @(posedge clk_i);
    fails++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk_i);
    #1 reset_i = 1'b0;
    rd_chk(6'h10, 32'h0000_0000);
    rd_chk(6'h11, 32'h6401_0001);
    rd_chk(6'h0d, 32'h0000_0044);
    rd_chk(6'h12, 32'h0000_0000);
    wr(6'h10, 4'hf, 32'hffff_ffff);
    check({31'h0, swap_en_o}, 32'h0000_0001);
    rd_chk(6'h10, 32'h0000_0001);
    xfer(32'h1122_3344, 32'h4433_2211);
    wr(6'h11, 4'hf, 32'hffff_ffff);
    wr(6'h0d, 4'hf, 32'h0000_0000);
    rd_chk(6'h11, 32'h6401_0001);
    rd_chk(6'h0d, 32'h0000_0044);
    // low byte disabled, so the stored bit must survive
    wr(6'h10, 4'he, 32'h0000_0000);
    rd_chk(6'h10, 32'h0000_0001);
    wr(6'h10, 4'h1, 32'h0000_0000);
    xfer(32'h1122_3344, 32'h1122_3344);
    // strobe gone: valid drops and the last quadlet stays put
    @(posedge clk_i) #1;
    check({31'h0, xfer_valid_o}, 32'h0000_0000);
    check(xfer_data_o, 32'h1122_3344);
    @(posedge clk_i) #1;
    eeprom_load_i = 1'b1;
    eeprom_swap_i = 1'b1;
    @(posedge clk_i) #1;
    eeprom_load_i = 1'b0;
    check({31'h0, swap_en_o}, 32'h0000_0001);
    rd_chk(6'h10, 32'h0000_0001);
    // mid-run reset clears the swap bit and the held quadlet
    @(posedge clk_i) #1;
    reset_i = 1'b1;
    repeat (3) @(posedge clk_i);
    #1 reset_i = 1'b0;
    check({31'h0, swap_en_o}, 32'h0000_0000);
    check({31'h0, xfer_valid_o}, 32'h0000_0000);
    check(xfer_data_o, 32'h0000_0000);
    check({31'h0, rsp.ack}, 32'h0000_0000);
    rd_chk(6'h10, 32'h0000_0000);
    // load and lane-0 write in one cycle: the load must win
    fork
      wr(6'h10, 4'h1, 32'h0000_0001);
      begin
        @(posedge clk_i) #1;
        eeprom_load_i = 1'b1;
        eeprom_swap_i = 1'b0;
        @(posedge clk_i) #1;
        eeprom_load_i = 1'b0;
      end
    join
    check({31'h0, swap_en_o}, 32'h0000_0000);
    rd_chk(6'h10, 32'h0000_0000);
    // every mirror combination
    for (int i = 0; i < 8; i++) begin
      misc_i = 3'(i);
      rd_chk(6'h11, {i[2], 1'b1, i[1], 2'b00, i[0], 10'h001, 16'h0001});
    end
    end_of_test();
  end
endmodule
